// ---- core/cxr_pkg.sv ----
package cxr_pkg;
   localparam logic [1:0] OFF_INDEX_POINTER = 2'h0;
   localparam logic [1:0] OFF_DATA_WINDOW = 2'h1;
   localparam logic [4:0] IDX_EXT_ACCESS = 5'h17;
   localparam logic [1:0] MODE_ENHANCED = 2'h3;
   localparam int POS_INIT = 7;
   localparam int POS_MCE = 6;
   localparam int POS_TRD = 5;
   localparam int POS_XSEL = 3;
   localparam int POS_XHI = 2;
   localparam logic [4:0] X_MIC_LEFT = 5'h02;
   localparam logic [4:0] X_MIC_RIGHT = 5'h03;
   localparam logic [4:0] X_SYNTH_MIX = 5'h04;
   localparam logic [4:0] X_VERSION_ID = 5'h19;
   localparam logic [7:0] RST_INDEX_POINTER = 8'h40;
   localparam logic [7:0] RST_MIC = 8'h5f;
   localparam logic [7:0] RST_EXT = 8'h00;
   localparam logic [4:0] GAIN_MUTE_CODE = 5'h1f;
   localparam logic [4:0] GAIN_LAST_STEP = 5'h1e;
   localparam logic [4:0] GAIN_ZERO_DB = 5'h0f;
   typedef struct packed {
      logic [1:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cxr_req_t;
   typedef struct packed {
      logic left_in_mute;
      logic left_out_mute;
      logic right_in_mute;
      logic right_out_mute;
      logic boost;
      logic [4:0] gain;
      logic mic_muted;
   } cxr_mic_t;
endpackage

// ---- core/cxr_mic_ctl.sv ----
`timescale 1ns/1ps
module cxr_mic_ctl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output logic boost_ff,
   output logic [4:0] gain_ff,
   output logic muted_ff
);
   // Shared gain/boost storage for both microphone views
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boost_ff <= cxr_pkg::RST_MIC[5];
         gain_ff <= cxr_pkg::RST_MIC[4:0];
         muted_ff <= 1'b0;
      end else if (wr_en) begin
         boost_ff <= wdata[5];
         gain_ff <= wdata[4:0];
         if (wdata[4:0] != cxr_pkg::GAIN_MUTE_CODE) begin
            muted_ff <= 1'b0;
         end else if (!(wdata[5] && gain_ff == cxr_pkg::GAIN_LAST_STEP)) begin
            muted_ff <= 1'b1;
         end // Boosted step to all-ones keeps previous volume
      end
   end
endmodule

// ---- core/cxr_ext_regs.sv ----
`timescale 1ns/1ps
// Operation
// - Decode four direct byte registers at base
// - Index pointer plus data window reach indirect
// - Extended bank only in enhanced mode three
// - Select bit turns index into data
// - Index pointer write clears select bit
// - Extended index field layout
// - Index pointer field layout
// - Mic gain 1.5 dB steps, ones mutes
// - Boosted step to ones keeps volume
// - Boost bit adds 20 dB gain
// - Right mic gain shares left storage
// - Mic bits mute input/output mixer feeds
// - Synthesis mixer register field layout
// - Aliased registers share control storage
// - Registers 0 and 1 do nothing
module cxr_ext_regs #(
   parameter logic [2:0] VERSION_NUMBER = 3'h1, // Arbitrary value
   parameter logic [4:0] CHIP_IDENTIFIER = 5'h05 // Arbitrary value
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire cxr_pkg::cxr_req_t req,
   input wire logic [1:0] codec_mode,
   output logic [7:0] rdata_ff,
   output logic rvalid_ff,
   output logic [7:0] index_pointer_ff,
   output cxr_pkg::cxr_mic_t mic_ff,
   output logic mono_in_right_mute_ff,
   output logic [1:0] left_input_summer_atten_ff,
   output logic internal_synth_enable_ff,
   output logic [7:0] ind_wr_data_ff,
   output logic [4:0] ind_wr_index_ff,
   output logic ind_wr_ff,
   output logic [7:0] alias_wr_data_ff,
   output logic [4:0] alias_wr_index_ff,
   output logic alias_wr_ff,
   input wire logic [7:0] ind_rdata,
   input wire logic [7:0] alias_rdata
);
   typedef enum logic {CXR_ADDR, CXR_DATA} cxr_xstate_t;
   cxr_xstate_t xstate_ff;
   logic [4:0] xindex_ff;
   logic [7:0] ext_ff [0:31];
   logic enh;
   logic at_ext;
   logic win_wr;
   logic win_rd;
   logic ptr_wr;
   logic ext_data_wr;
   logic is_alias;
   logic mic_wr;
   logic boost;
   logic [4:0] gain;
   logic muted;
   logic [7:0] nxt_rdata;
   logic [7:0] ext_view;

   assign enh = (codec_mode == cxr_pkg::MODE_ENHANCED);
   assign ptr_wr = req.wr && req.addr == cxr_pkg::OFF_INDEX_POINTER;
   assign win_wr = req.wr && req.addr == cxr_pkg::OFF_DATA_WINDOW;
   assign win_rd = req.rd && req.addr == cxr_pkg::OFF_DATA_WINDOW;
   // Outside enhanced mode index 17h is an ordinary indirect register
   assign at_ext = enh && index_pointer_ff[4:0] == cxr_pkg::IDX_EXT_ACCESS;
   assign ext_data_wr = win_wr && at_ext && xstate_ff == CXR_DATA;
   assign is_alias = (xindex_ff == 5'd23) || (xindex_ff == 5'd24) ||
                     (xindex_ff >= 5'd26 && xindex_ff <= 5'd30);
   assign mic_wr = ext_data_wr &&
                   (xindex_ff == cxr_pkg::X_MIC_LEFT || xindex_ff == cxr_pkg::X_MIC_RIGHT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index_pointer_ff <= cxr_pkg::RST_INDEX_POINTER;
      end else if (ptr_wr) begin
         index_pointer_ff <= req.wdata;
      end
   end

   // Two-state address/data selector of the extended index register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xstate_ff <= CXR_ADDR;
         xindex_ff <= 5'h00;
      end else if (ptr_wr) begin
         xstate_ff <= CXR_ADDR;
      end else if (!enh) begin
         xstate_ff <= CXR_ADDR;
      end else if (win_wr && at_ext && xstate_ff == CXR_ADDR) begin
         xindex_ff <= {req.wdata[cxr_pkg::POS_XHI], req.wdata[7:4]};
         if (req.wdata[cxr_pkg::POS_XSEL]) begin
            xstate_ff <= CXR_DATA;
         end
      end
   end

   // Plain extended storage; only reserved slots 0 and 1 and ID slot 25 are not written here
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_ext
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ext_ff[gi] <= cxr_pkg::RST_EXT;
            end else if (ext_data_wr && xindex_ff == gi && gi > 1 && gi != 25) begin
               ext_ff[gi] <= req.wdata;
            end
         end
      end
   endgenerate

   cxr_mic_ctl u_mic (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(mic_wr),
      .wdata(req.wdata),
      .boost_ff(boost),
      .gain_ff(gain),
      .muted_ff(muted)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mic_ff <= '0;
      end else begin
         mic_ff.left_in_mute <= ext_ff[2][7];
         mic_ff.left_out_mute <= ext_ff[2][6];
         mic_ff.right_in_mute <= ext_ff[3][7];
         mic_ff.right_out_mute <= ext_ff[3][6];
         mic_ff.boost <= boost;
         mic_ff.gain <= gain;
         mic_ff.mic_muted <= muted;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mono_in_right_mute_ff <= 1'b0;
         left_input_summer_atten_ff <= 2'h0;
         internal_synth_enable_ff <= 1'b0;
      end else begin
         mono_in_right_mute_ff <= ext_ff[4][7];
         left_input_summer_atten_ff <= ext_ff[4][6:5];
         internal_synth_enable_ff <= ext_ff[4][4];
      end
   end

   // Indirect and alias write strobes go out to the owners of that storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ind_wr_ff <= 1'b0;
         ind_wr_index_ff <= 5'h00;
         ind_wr_data_ff <= 8'h00;
         alias_wr_ff <= 1'b0;
         alias_wr_index_ff <= 5'h00;
         alias_wr_data_ff <= 8'h00;
      end else begin
         ind_wr_ff <= win_wr && !at_ext;
         ind_wr_index_ff <= index_pointer_ff[4:0];
         ind_wr_data_ff <= req.wdata;
         alias_wr_ff <= ext_data_wr && is_alias;
         alias_wr_index_ff <= xindex_ff;
         alias_wr_data_ff <= req.wdata;
      end
   end

   always_comb begin
      ext_view = 8'h00;
      case (xindex_ff)
         5'd0, 5'd1: ext_view = 8'h00;
         cxr_pkg::X_MIC_LEFT: ext_view = {ext_ff[2][7:6], boost, gain};
         cxr_pkg::X_MIC_RIGHT: ext_view = {ext_ff[3][7:6], boost, gain};
         cxr_pkg::X_SYNTH_MIX: ext_view = {ext_ff[4][7:4], 4'h0};
         cxr_pkg::X_VERSION_ID: ext_view = {VERSION_NUMBER, CHIP_IDENTIFIER};
         default: ext_view = is_alias ? alias_rdata : ext_ff[xindex_ff];
      endcase
   end

   always_comb begin
      nxt_rdata = 8'h00;
      case (req.addr)
         cxr_pkg::OFF_INDEX_POINTER: nxt_rdata = index_pointer_ff;
         cxr_pkg::OFF_DATA_WINDOW: begin
            if (!at_ext) begin
               nxt_rdata = ind_rdata;
            end else if (xstate_ff == CXR_DATA) begin
               nxt_rdata = ext_view;
            end else begin
               nxt_rdata = {xindex_ff[3:0], 1'b0, xindex_ff[4], 2'h0};
            end
         end
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= req.rd;
         if (req.rd) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   AST_PTR_CLEARS_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      ptr_wr
      |=> xstate_ff == CXR_ADDR)
      else $error("select not cleared");
   AST_SEL_SETS_DATA: assert property (@(posedge clk) disable iff (!rst_n)
      win_wr && at_ext && xstate_ff == CXR_ADDR && req.wdata[3] && !ptr_wr
      |=> xstate_ff == CXR_DATA)
      else $error("select not set");
   AST_MODE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
      !enh
      |=> xstate_ff == CXR_ADDR)
      else $error("ext outside mode");
   AST_ID_READ: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == 2'h1 && at_ext && xstate_ff == CXR_DATA && xindex_ff == 5'd25
      |=> rdata_ff == {VERSION_NUMBER, CHIP_IDENTIFIER})
      else $error("bad id");
   AST_MIC_SHARED: assert property (@(posedge clk) disable iff (!rst_n)
      mic_wr
      |=> gain == $past(req.wdata[4:0]) && boost == $past(req.wdata[5]))
      else $error("mic not shared");
   AST_BOOST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      mic_wr && req.wdata[5] && req.wdata[4:0] == 5'h1f && gain == 5'h1e
      |=> muted == $past(muted))
      else $error("boost step muted");
   AST_GAIN_MUTE: assert property (@(posedge clk) disable iff (!rst_n)
      mic_wr && !req.wdata[5] && req.wdata[4:0] == 5'h1f
      |=> muted)
      else $error("no mute");
   AST_XINDEX_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      win_wr && at_ext && xstate_ff == CXR_ADDR && !ptr_wr
      |=> xindex_ff == {$past(req.wdata[2]), $past(req.wdata[7:4])})
      else $error("bad ext index");
   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == 2'h1 && at_ext && xstate_ff == CXR_DATA && xindex_ff < 5'd2
      |=> rdata_ff == 8'h00)
      else $error("reserved nonzero");

   // Pointer register and direct decode
   AST_PTR_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
      ptr_wr
      |=> index_pointer_ff == $past(req.wdata))
      else $error("pointer not loaded");
   AST_PTR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !ptr_wr
      |=> index_pointer_ff == $past(index_pointer_ff))
      else $error("pointer changed");
   AST_PTR_READ: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == cxr_pkg::OFF_INDEX_POINTER
      |=> rdata_ff == $past(index_pointer_ff))
      else $error("pointer read wrong");
   AST_HIGH_OFFSET_READ: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr[1]
      |=> rdata_ff == 8'h00)
      else $error("upper offset nonzero");
   AST_RVALID_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd
      |=> rvalid_ff)
      else $error("read not answered");
   AST_RVALID_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      !req.rd
      |=> !rvalid_ff)
      else $error("spurious read valid");

   // Plain indirect path through the data window
   AST_IND_READ: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == cxr_pkg::OFF_DATA_WINDOW && !at_ext
      |=> rdata_ff == $past(ind_rdata))
      else $error("indirect read wrong");
   AST_IND_WR_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
      win_wr && !at_ext
      |=> ind_wr_ff)
      else $error("indirect write lost");
   AST_IND_WR_FIELDS: assert property (@(posedge clk) disable iff (!rst_n)
      win_wr && !at_ext
      |=> ind_wr_index_ff == $past(index_pointer_ff[4:0]) && ind_wr_data_ff == $past(req.wdata))
      else $error("indirect write fields wrong");
   AST_IND_WR_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      !(win_wr && !at_ext)
      |=> !ind_wr_ff)
      else $error("spurious indirect write");
   AST_MODE_PLAIN: assert property (@(posedge clk) disable iff (!rst_n)
      !enh && win_wr
      |=> ind_wr_ff)
      else $error("window write not plain");

   // Extended address/data selector
   AST_XADDR_READ: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == 2'h1 && at_ext && xstate_ff == CXR_ADDR
      |=> rdata_ff[3] == 1'b0 && rdata_ff[1:0] == 2'h0)
      else $error("index read layout");
   AST_XSEL_STAY_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
      win_wr && at_ext && xstate_ff == CXR_ADDR && !req.wdata[3]
      |=> xstate_ff == CXR_ADDR)
      else $error("select set without bit");
   AST_DATA_STAYS: assert property (@(posedge clk) disable iff (!rst_n)
      xstate_ff == CXR_DATA && enh && !ptr_wr
      |=> xstate_ff == CXR_DATA)
      else $error("select dropped");
   AST_XINDEX_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      xstate_ff == CXR_DATA
      |=> xindex_ff == $past(xindex_ff))
      else $error("index moved in data state");

   // Alias forwarding
   AST_ALIAS_STROBE: assert property (@(posedge clk) disable iff (!rst_n)
      ext_data_wr && is_alias
      |=> alias_wr_ff && alias_wr_data_ff == $past(req.wdata) && alias_wr_index_ff == $past(xindex_ff))
      else $error("alias write lost");
   AST_ALIAS_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      !(ext_data_wr && is_alias)
      |=> !alias_wr_ff)
      else $error("spurious alias write");

   // Mixer control fields
   AST_SYNTH_STORE: assert property (@(posedge clk) disable iff (!rst_n)
      ext_data_wr && xindex_ff == cxr_pkg::X_SYNTH_MIX
      |=> ext_ff[4] == $past(req.wdata))
      else $error("synth register not stored");
   AST_SYNTH_OUT: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1
      |=> {mono_in_right_mute_ff, left_input_summer_atten_ff, internal_synth_enable_ff} == $past(ext_ff[4][7:4]))
      else $error("synth outputs stale");
   AST_SYNTH_VIEW: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == 2'h1 && at_ext && xstate_ff == CXR_DATA && xindex_ff == 5'd4
      |=> rdata_ff[3:0] == 4'h0)
      else $error("synth low bits nonzero");
   AST_MIC_GAIN_OUT: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1
      |=> mic_ff.gain == $past(gain) && mic_ff.boost == $past(boost))
      else $error("mic gain output stale");
   AST_MIC_MUTE_BITS: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1
      |=> mic_ff.left_in_mute == $past(ext_ff[2][7]) && mic_ff.right_out_mute == $past(ext_ff[3][6]))
      else $error("mic mute outputs stale");
   AST_MIC_VIEW: assert property (@(posedge clk) disable iff (!rst_n)
      req.rd && req.addr == 2'h1 && at_ext && xstate_ff == CXR_DATA && xindex_ff == 5'd3
      |=> rdata_ff[5:0] == $past({boost, gain}))
      else $error("right mic view not shared");
   AST_GAIN_UNMUTE: assert property (@(posedge clk) disable iff (!rst_n)
      mic_wr && req.wdata[4:0] != 5'h1f
      |=> !muted)
      else $error("mute kept on gain code");
endmodule

// ---- verification/cxr_host_model.sv ----
`timescale 1ns/1ps
module cxr_host_model (
   input wire logic clk,
   output cxr_pkg::cxr_req_t req,
   input wire logic [7:0] rdata_ff,
   input wire logic rvalid_ff
);
   initial req = '0;
   // Idle bus shows inverted leftovers so a stale sample cannot pass
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clk);
      req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(negedge clk);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clk);
      // Read answer stands for one cycle only, so take it before releasing
      d = rvalid_ff ? rdata_ff : 8'hxx;
      req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'ha5};
   endtask
   task automatic xsel(input logic [4:0] x);
      wr(2'h0, 8'h17);
      wr(2'h1, {x[3:0], 1'b1, x[4], 2'b00});
   endtask
endmodule

// ---- verification/codec_extended_register_access_test.sv ----
`timescale 1ns/1ps
module codec_extended_register_access_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] codec_mode = 2'h3;
   cxr_pkg::cxr_req_t req;
   cxr_pkg::cxr_mic_t mic_ff;
   logic [7:0] rdata_ff, index_pointer_ff, ind_wr_data_ff, alias_wr_data_ff, ind_rdata, v;
   logic [4:0] ind_wr_index_ff, alias_wr_index_ff;
   logic [1:0] atten;
   logic rvalid_ff, mono, synth;
   logic iwr, awr;
   int n_mismatch = 0;
   int n_tests = 0;
   assign ind_rdata = {3'h5, index_pointer_ff[4:0]};
   cxr_ext_regs #(.VERSION_NUMBER(3'h1), .CHIP_IDENTIFIER(5'h05)) cxr_ext_regs_inst (
      .clk(clk), .rst_n(rst_n), .req(req), .codec_mode(codec_mode), .rdata_ff(rdata_ff),
      .rvalid_ff(rvalid_ff), .index_pointer_ff(index_pointer_ff), .mic_ff(mic_ff),
      .mono_in_right_mute_ff(mono), .left_input_summer_atten_ff(atten),
      .internal_synth_enable_ff(synth), .ind_wr_data_ff(ind_wr_data_ff),
      .ind_wr_index_ff(ind_wr_index_ff), .ind_wr_ff(iwr), .alias_wr_data_ff(alias_wr_data_ff),
      .alias_wr_index_ff(alias_wr_index_ff), .alias_wr_ff(awr), .ind_rdata(ind_rdata),
      .alias_rdata(8'h3c));
   cxr_host_model cxr_host_model_inst (
      .clk(clk), .req(req), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic w(input logic [1:0] a, input logic [7:0] d);
      cxr_host_model_inst.wr(a, d);
   endtask
   task automatic r(input logic [1:0] a);
      cxr_host_model_inst.rd(a, v);
   endtask
   task automatic x(input logic [4:0] i);
      cxr_host_model_inst.xsel(i);
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      chk("pointer", index_pointer_ff, cxr_pkg::RST_INDEX_POINTER);
      w(2'h0, 8'h17);
      chk("gain", {3'h0, mic_ff.gain}, 8'h1f);
      r(2'h1);
      chk("select", {7'h0, v[3]}, 8'h00);
   endtask
   task automatic t_direct;
      w(2'h0, 8'h25);
      chk("pointer", index_pointer_ff, 8'h25);
      r(2'h0);
      chk("rd0", v, 8'h25);
      r(2'h1);
      chk("window", v, 8'ha5);
      w(2'h1, 8'h77);
      chk("ind_wr", {7'h0, iwr}, 8'h01);
      chk("ind_data", ind_wr_data_ff, 8'h77);
      chk("ind_index", {3'h0, ind_wr_index_ff}, 8'h05);
      r(2'h3);
      chk("rd3", v, 8'h00);
   endtask
   task automatic t_ext;
      x(5'h04);
      w(2'h1, 8'hbf);
      @(negedge clk);
      chk("synth", {mono, atten, synth, 4'h0}, 8'hb0);
      r(2'h1);
      chk("synth_rd", v, 8'hb0);
      x(5'h19);
      w(2'h1, 8'h00);
      r(2'h1);
      chk("id", v, 8'h25);
      x(5'h00);
      w(2'h1, 8'hff);
      r(2'h1);
      chk("rsvd", v, 8'h00);
      x(5'h17);
      w(2'h1, 8'ha0);
      chk("alias_wr", {7'h0, awr}, 8'h01);
      chk("alias_data", alias_wr_data_ff, 8'ha0);
      chk("alias_index", {3'h0, alias_wr_index_ff}, 8'h17);
      r(2'h1);
      chk("alias_rd", v, 8'h3c);
      w(2'h0, 8'h17);
      r(2'h1);
      chk("select", {7'h0, v[3]}, 8'h00);
   endtask
   task automatic t_mic;
      x(5'h02);
      w(2'h1, 8'hd4);
      @(negedge clk);
      chk("left_mutes", {6'h0, mic_ff.left_in_mute, mic_ff.left_out_mute}, 8'h03);
      chk("gain", {3'h0, mic_ff.gain}, 8'h14);
      x(5'h03);
      r(2'h1);
      chk("right_view", v & 8'h3f, 8'h14);
      w(2'h1, 8'hbe);
      @(negedge clk);
      chk("right_mutes", {6'h0, mic_ff.right_in_mute, mic_ff.right_out_mute}, 8'h02);
      chk("boost", {7'h0, mic_ff.boost}, 8'h01);
      w(2'h1, 8'hbf);
      @(negedge clk);
      chk("boost_keep", {7'h0, mic_ff.mic_muted}, 8'h00);
      w(2'h1, 8'h1e);
      w(2'h1, 8'h1f);
      @(negedge clk);
      chk("muted", {7'h0, mic_ff.mic_muted}, 8'h01);
      x(5'h02);
      r(2'h1);
      chk("left_view", v & 8'h3f, 8'h1f);
   endtask
   task automatic t_mode;
      @(negedge clk);
      codec_mode = 2'h0;
      w(2'h0, 8'h17);
      w(2'h1, 8'h4c);
      chk("plain_wr", {7'h0, iwr}, 8'h01);
      chk("plain_index", {3'h0, ind_wr_index_ff}, 8'h17);
      chk("plain_data", ind_wr_data_ff, 8'h4c);
      chk("synth_kept", {mono, atten, synth, 4'h0}, 8'hb0);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      t_reset;
      t_direct;
      t_ext;
      t_mic;
      t_mode;
      tally_and_finish;
   end
   // Whole sequence needs under a hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      tally_and_finish;
   end
endmodule
